/* src/dmcf_defines.svh */
// constants of the fifth dram mode-control register and its logic
`ifndef DMCF_DEFINES_SVH
`define DMCF_DEFINES_SVH

// register image layout, as loaded from bank-group, bank and address pins
`define DMCF_IMG_W        22
`define DMCF_SEL_HI       20
`define DMCF_SEL_LO       18
`define DMCF_BIT_RD_INV   12
`define DMCF_BIT_WR_INV   11
`define DMCF_BIT_WR_MASK  10
`define DMCF_BIT_PERSIST  9
`define DMCF_PARK_HI      8
`define DMCF_PARK_LO      6
`define DMCF_BIT_ODT_OFF  5
`define DMCF_BIT_PAR_ERR  4
`define DMCF_BIT_CRC_ERR  3
`define DMCF_LAT_HI       2
`define DMCF_LAT_LO       0

// target select codes
`define DMCF_SEL_SELF     3'h5
`define DMCF_SEL_UNUSED   3'h7

// parity latency codes and their clock counts
`define DMCF_LAT_CODE_OFF 3'h0
`define DMCF_LAT_CODE_4   3'h1
`define DMCF_LAT_CODE_5   3'h2
`define DMCF_LAT_CODE_6   3'h3
`define DMCF_LAT_CLK_4    4
`define DMCF_LAT_CLK_5    5
`define DMCF_LAT_CLK_6    6
`define DMCF_LAT_MAX      6

// reset value of the whole register
`define DMCF_MODE_RESET   22'h000000

// data-bus organisation
`define DMCF_DQ_WIDTH     8
`define DMCF_DQ_X4        4

`endif

/* src/dmcf_pkg.sv */
// types shared by the mode-control register logic
package dmcf_pkg;

  // command/address pins covered by parity; ras/cas/we double as a16..a14
  typedef struct packed {
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic        a17;
    logic [13:0] addr;
    logic        par;
  } dmcf_ca_t;

  // register layout, bit 21 down to bit 0
  typedef struct packed {
    logic        rsv21;
    logic [2:0]  sel;
    logic        rsv17;
    logic [2:0]  gap;
    logic        rsv13;
    logic        rd_inv;
    logic        wr_inv;
    logic        wr_mask;
    logic        persist;
    logic [2:0]  park;
    logic        odt_off;
    logic        par_err;
    logic        crc_err;
    logic [2:0]  lat;
  } dmcf_mode_t;

  typedef enum logic [0:0] {
    DMCF_ST_RUN,
    DMCF_ST_MAXSAVE
  } dmcf_state_t;

  typedef enum logic [1:0] {
    DMCF_PU_NONE,
    DMCF_PU_MASK,
    DMCF_PU_INVERT
  } dmcf_pin_use_t;

endpackage

/* src/dmcf_parity.sv */
// command/address parity check with programmable latency
`timescale 1ns/1ps
`include "dmcf_defines.svh"

module dmcf_parity
  import dmcf_pkg::*;
#(
  parameter int MAX_LAT = `DMCF_LAT_MAX
)(
  // clock and reset
  input  wire logic     clk_sys,
  input  wire logic     resetn,
  // command in
  input  wire logic     in_valid,
  input  dmcf_ca_t      in_word,
  // settings
  input  wire logic [2:0] lat_code,
  input  wire logic     check_en,
  // command out
  output logic          out_valid_q,
  output dmcf_ca_t      out_word_q,
  output logic          err_pulse_q
);

  logic [MAX_LAT-1:0] vld_q, vld_d;
  logic [MAX_LAT-1:0] bad_q, bad_d;
  dmcf_ca_t           word_q [MAX_LAT];
  dmcf_ca_t           word_d [MAX_LAT];
  logic               t_v, t_b, out_valid_d, err_d;
  int                 depth;
  dmcf_ca_t           t_w;

  always_comb
  begin
    // reserved codes behave as parity disabled: no check, no delay
    depth = 0;
    t_v   = in_valid;
    t_b   = 1'b0;
    t_w   = in_word;
    case (lat_code)
      `DMCF_LAT_CODE_4:
      begin
        depth = `DMCF_LAT_CLK_4;
        t_v = vld_q[`DMCF_LAT_CLK_4-1];
        t_b = bad_q[`DMCF_LAT_CLK_4-1];
        t_w = word_q[`DMCF_LAT_CLK_4-1];
      end
      `DMCF_LAT_CODE_5:
      begin
        depth = `DMCF_LAT_CLK_5;
        t_v = vld_q[`DMCF_LAT_CLK_5-1];
        t_b = bad_q[`DMCF_LAT_CLK_5-1];
        t_w = word_q[`DMCF_LAT_CLK_5-1];
      end
      `DMCF_LAT_CODE_6:
      begin
        depth = `DMCF_LAT_CLK_6;
        t_v = vld_q[`DMCF_LAT_CLK_6-1];
        t_b = bad_q[`DMCF_LAT_CLK_6-1];
        t_w = word_q[`DMCF_LAT_CLK_6-1];
      end
      default:
      begin
        t_v = in_valid;
      end
    endcase
    // entries past the tap are dropped: when a mode set moves the tap
    // deeper, a command already taken must not come out a second time
    vld_d[0]  = in_valid & (depth > 0);
    bad_d[0]  = ^in_word; // even parity over all covered pins
    word_d[0] = in_word;
    for (int i = 1; i < MAX_LAT; i++)
    begin
      vld_d[i]  = vld_q[i-1] & (i < depth);
      bad_d[i]  = bad_q[i-1];
      word_d[i] = word_q[i-1];
    end
    // a failing command is not executed while check_en is set
    out_valid_d = t_v & ~(t_b & check_en);
    err_d       = t_v & t_b & check_en;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      vld_q       <= '0;
      bad_q       <= '0;
      out_valid_q <= 1'b0;
      err_pulse_q <= 1'b0;
      out_word_q  <= '0;
      for (int i = 0; i < MAX_LAT; i++)
        word_q[i] <= '0;
    end
    else
    begin
      vld_q       <= vld_d;
      bad_q       <= bad_d;
      out_valid_q <= out_valid_d;
      err_pulse_q <= err_d;
      out_word_q  <= t_w;
      for (int i = 0; i < MAX_LAT; i++)
        word_q[i] <= word_d[i];
    end
  end

  a_lat_four: assert property (@(posedge clk_sys) disable iff (!resetn)
    (in_valid && !(^in_word) && lat_code == `DMCF_LAT_CODE_4)
    ##1 (lat_code == `DMCF_LAT_CODE_4) [*4]
    |=> out_valid_q)
    else $error("command not released four clocks later");

endmodule // dmcf_parity

/* src/dmcf_top.sv */
// fifth dram mode-control register, its loading and the logic it steers
//
// What this block does
// - max power saving: ignore commands except exit
// - mode set loads register from bank/address pins
// - select code picks target; unused code ignored
// - bits 12, 11 enable read/write inversion
// - bit 10 masks write bytes, writes only
// - no read inversion during multipurpose readout
// - shared pin features only in x8, x16
// - bit 9 keeps parity checking after error
// - bits 8:6 pick parked termination strength
// - bit 5 drops termination input in power-down
// - bits 4, 3 flag parity and crc errors
// - bits 2:0 pick parity latency four to six
// - error flags stick until cleared by mode set
// - parity checked over command and address pins
// - parity excludes clock enable, termination, select
`timescale 1ns/1ps
`include "dmcf_defines.svh"

module dmcf_top
  import dmcf_pkg::*;
#(
  parameter int DQ_WIDTH = `DMCF_DQ_WIDTH
)(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // device pins
  input  wire logic       cs_n_pin,
  input  wire logic       cke_pin,
  input  wire logic       odt_pin,
  input  dmcf_ca_t        ca_pin,
  // internal status from the core
  input  wire logic       read_xfer,
  input  wire logic       write_xfer,
  input  wire logic       mpr_read,
  input  wire logic       power_down,
  input  wire logic       mps_enter,
  input  wire logic       mps_exit,
  input  wire logic       crc_err_evt,
  // register contents
  output dmcf_mode_t      mode_reg_q,
  // executed commands
  output logic            cmd_valid_q,
  output dmcf_ca_t        cmd_word_q,
  output logic            mrs_other_valid_q,
  output logic [2:0]      mrs_other_sel_q,
  output logic [21:0]     mrs_other_img_q,
  // steered functions
  output logic            rd_inv_apply_q,
  output logic            wr_inv_apply_q,
  output logic            wr_mask_apply_q,
  output dmcf_pin_use_t   pin_use_q,
  output logic            nom_term_q,
  output logic [2:0]      park_div_q,
  output logic            mps_active_q
);

  // x4 has no shared pin, so its features stay off whatever is written
  localparam logic SHARED_OK = (DQ_WIDTH != `DMCF_DQ_X4);
  localparam int   SYNC_W    = $bits(dmcf_ca_t) + 3;

  // two-stage pin synchroniser
  logic [SYNC_W-1:0] sync1_q, sync1_d, sync2_q;
  dmcf_ca_t          ca_s;
  logic              cs_n_s, cke_s, odt_s;

  always_comb
  begin
    sync1_d = {ca_pin, cs_n_pin, cke_pin, odt_pin};
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync1_q;
    end
  end

  assign {ca_s, cs_n_s, cke_s, odt_s} = sync2_q;

  // max power saving state
  dmcf_state_t st_q, st_d;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      DMCF_ST_RUN:
        if (mps_enter)
          st_d = DMCF_ST_MAXSAVE;
      DMCF_ST_MAXSAVE:
        if (mps_exit)
          st_d = DMCF_ST_RUN; // only exit leaves, besides reset
      default:
        st_d = DMCF_ST_RUN;
    endcase
  end

  // command path through the parity checker
  logic     par_in_valid, lat_ok, check_en;
  logic     par_out_valid, par_err_pulse;
  dmcf_ca_t par_out_word;

  always_comb
  begin
    // select, clock enable and the run state gate the command only
    par_in_valid = ~cs_n_s & cke_s & (st_q == DMCF_ST_RUN);
    lat_ok = (mode_reg_q.lat == `DMCF_LAT_CODE_4)
           | (mode_reg_q.lat == `DMCF_LAT_CODE_5)
           | (mode_reg_q.lat == `DMCF_LAT_CODE_6);
    check_en = lat_ok & (mode_reg_q.persist | ~mode_reg_q.par_err);
  end

  dmcf_parity #(
    .MAX_LAT (`DMCF_LAT_MAX)
  ) u_parity (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .in_valid    (par_in_valid),
    .in_word     (ca_s),
    .lat_code    (mode_reg_q.lat),
    .check_en    (check_en),
    .out_valid_q (par_out_valid),
    .out_word_q  (par_out_word),
    .err_pulse_q (par_err_pulse)
  );

  // mode set decode
  logic                   is_mrs, to_self, to_other;
  logic [`DMCF_IMG_W-1:0] img;
  logic [2:0]             sel;

  always_comb
  begin
    // ras, cas, we low carry no register bits
    is_mrs = par_out_valid & par_out_word.act_n & ~par_out_word.ras_n
           & ~par_out_word.cas_n & ~par_out_word.we_n;
    img = {par_out_word.bg, par_out_word.ba, par_out_word.a17, 3'h0,
           par_out_word.addr};
    sel = img[`DMCF_SEL_HI:`DMCF_SEL_LO];
    to_self  = is_mrs & (sel == `DMCF_SEL_SELF);
    to_other = is_mrs & (sel != `DMCF_SEL_SELF)
             & (sel != `DMCF_SEL_UNUSED);
  end

  // register, command and steering outputs
  dmcf_mode_t      mode_d;
  logic            cmd_valid_d, mrs_other_valid_d;
  logic [2:0]      park_div_d;
  logic            rd_inv_d, wr_inv_d, wr_mask_d, nom_term_d;
  dmcf_pin_use_t   pin_use_d;

  always_comb
  begin
    mode_d = mode_reg_q;
    if (to_self)
    begin
      // reserved bits are not stored and read as zero
      mode_d.rd_inv  = img[`DMCF_BIT_RD_INV] & SHARED_OK;
      mode_d.wr_inv  = img[`DMCF_BIT_WR_INV] & SHARED_OK;
      mode_d.wr_mask = img[`DMCF_BIT_WR_MASK] & SHARED_OK;
      mode_d.persist = img[`DMCF_BIT_PERSIST];
      mode_d.park    = img[`DMCF_PARK_HI:`DMCF_PARK_LO];
      mode_d.odt_off = img[`DMCF_BIT_ODT_OFF];
      mode_d.par_err = img[`DMCF_BIT_PAR_ERR];
      mode_d.crc_err = img[`DMCF_BIT_CRC_ERR];
      mode_d.lat     = img[`DMCF_LAT_HI:`DMCF_LAT_LO];
    end
    // a detected error wins over a clear in the same cycle
    if (par_err_pulse)
      mode_d.par_err = 1'b1;
    if (crc_err_evt)
      mode_d.crc_err = 1'b1;

    cmd_valid_d       = par_out_valid & ~is_mrs;
    mrs_other_valid_d = to_other;

    // inversion and masking; masking never touches reads
    rd_inv_d  = mode_reg_q.rd_inv & read_xfer & ~mpr_read;
    wr_inv_d  = mode_reg_q.wr_inv & write_xfer;
    wr_mask_d = mode_reg_q.wr_mask & write_xfer;
    // write inversion with masking is illegal; masking is shown if both
    if (mode_reg_q.wr_mask)
      pin_use_d = DMCF_PU_MASK;
    else if (mode_reg_q.rd_inv | mode_reg_q.wr_inv)
      pin_use_d = DMCF_PU_INVERT;
    else
      pin_use_d = DMCF_PU_NONE;

    // odt input ignored in power-down when its buffer is off
    nom_term_d = odt_s & ~(power_down & mode_reg_q.odt_off)
               & (st_q == DMCF_ST_RUN);

    // parked strength as divisor of the calibration resistor
    case (mode_reg_q.park)
      3'h1: park_div_d = 3'h4;
      3'h2: park_div_d = 3'h2;
      3'h3: park_div_d = 3'h6;
      3'h4: park_div_d = 3'h1;
      3'h5: park_div_d = 3'h5;
      3'h6: park_div_d = 3'h3;
      3'h7: park_div_d = 3'h7;
      default: park_div_d = 3'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q              <= DMCF_ST_RUN;
      mode_reg_q        <= `DMCF_MODE_RESET;
      cmd_valid_q       <= 1'b0;
      cmd_word_q        <= '0;
      mrs_other_valid_q <= 1'b0;
      mrs_other_sel_q   <= 3'h0;
      mrs_other_img_q   <= 22'h000000;
      rd_inv_apply_q    <= 1'b0;
      wr_inv_apply_q    <= 1'b0;
      wr_mask_apply_q   <= 1'b0;
      pin_use_q         <= DMCF_PU_NONE;
      nom_term_q        <= 1'b0;
      park_div_q        <= 3'h0;
      mps_active_q      <= 1'b0;
    end
    else
    begin
      st_q              <= st_d;
      mode_reg_q        <= mode_d;
      cmd_valid_q       <= cmd_valid_d;
      cmd_word_q        <= par_out_word;
      mrs_other_valid_q <= mrs_other_valid_d;
      mrs_other_sel_q   <= sel;
      mrs_other_img_q   <= img;
      rd_inv_apply_q    <= rd_inv_d;
      wr_inv_apply_q    <= wr_inv_d;
      wr_mask_apply_q   <= wr_mask_d;
      pin_use_q         <= pin_use_d;
      nom_term_q        <= nom_term_d;
      park_div_q        <= park_div_d;
      mps_active_q      <= (st_d == DMCF_ST_MAXSAVE);
    end
  end

  // checks
  a_mps_ignore: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_q == DMCF_ST_MAXSAVE) [*8] |-> !cmd_valid_q && !mrs_other_valid_q
    && $stable(mode_reg_q.lat))
    else $error("command acted on in max power saving");

  a_mrs_load: assert property (@(posedge clk_sys) disable iff (!resetn)
    to_self && !par_err_pulse |=> mode_reg_q.persist == $past(img[9])
    && mode_reg_q.lat == $past(img[2:0])
    && mode_reg_q.park == $past(img[8:6]))
    else $error("mode set did not load the register");

  a_sel_unused: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_mrs && sel == `DMCF_SEL_UNUSED && !par_err_pulse && !crc_err_evt
    |=> $stable(mode_reg_q) && !mrs_other_valid_q)
    else $error("unused select code had an effect");

  a_rsv_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_reg_q.rsv21 == 1'b0 && mode_reg_q.rsv17 == 1'b0
    && mode_reg_q.rsv13 == 1'b0)
    else $error("reserved bit reads one");

  a_mpr_noinv: assert property (@(posedge clk_sys) disable iff (!resetn)
    mpr_read |=> !rd_inv_apply_q)
    else $error("read inversion during readout");

  a_mask_reads: assert property (@(posedge clk_sys) disable iff (!resetn)
    !write_xfer |=> !wr_mask_apply_q && !wr_inv_apply_q)
    else $error("write function applied outside a write");

  a_nonpersist: assert property (@(posedge clk_sys) disable iff (!resetn)
    !mode_reg_q.persist && mode_reg_q.par_err |-> !check_en)
    else $error("parity still checked after error");

  a_err_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_reg_q.par_err && !to_self |=> mode_reg_q.par_err)
    else $error("parity error flag dropped without a clear");

  a_err_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    par_err_pulse || crc_err_evt |=> (mode_reg_q.par_err || !$past(
    par_err_pulse)) && (mode_reg_q.crc_err || !$past(crc_err_evt)))
    else $error("error event not recorded");

  a_term_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    power_down && mode_reg_q.odt_off |=> !nom_term_q)
    else $error("nominal termination in power-down");

  a_reset_zero: assert property (@(posedge clk_sys)
    $rose(resetn) |-> mode_reg_q == `DMCF_MODE_RESET && !cmd_valid_q)
    else $error("register not zero after reset");

  c_self_load: cover property (@(posedge clk_sys) disable iff (!resetn)
    to_self);
  c_other_load: cover property (@(posedge clk_sys) disable iff (!resetn)
    to_other);
  c_par_err: cover property (@(posedge clk_sys) disable iff (!resetn)
    par_err_pulse ##1 mode_reg_q.par_err);
  c_mps_cycle: cover property (@(posedge clk_sys) disable iff (!resetn)
    mps_active_q ##[1:20] !mps_active_q);

endmodule // dmcf_top

/* sim/dmcf_ctrl_model.sv */
// controller model driving command, address and termination pins
`timescale 1ns/1ps
module dmcf_ctrl_model
  import dmcf_pkg::*;
(
  // clock
  input  wire logic clk_sys,
  // device pins
  output logic      cs_n_pin,
  output logic      cke_pin,
  output logic      odt_pin,
  output dmcf_ca_t  ca_pin
);
  initial
  begin
    cs_n_pin = 1'b1;
    cke_pin  = 1'b1;
    odt_pin  = 1'b0;
    ca_pin   = '0;
  end

  // one-cycle command; bad flips the parity bit
  task automatic send(input dmcf_ca_t c, input logic bad);
    @(posedge clk_sys);
    #1;
    c.par    = (^c[23:1]) ^ bad;
    ca_pin   = c;
    cs_n_pin = 1'b0;
    @(posedge clk_sys);
    #1;
    cs_n_pin = 1'b1;
    // deselected bus shows the inverse so stale values never match
    ca_pin   = ~c;
  endtask

  task automatic mode_set(input logic [2:0] sel, input logic [21:0] img,
                          input logic bad);
    dmcf_ca_t c;
    c       = '0;
    c.act_n = 1'b1; // ras, cas, we stay low
    c.bg    = {1'b0, sel[2]};
    c.ba    = sel[1:0];
    c.addr  = {1'b0, img[12:0]};
    // shared pin: write inversion wins over masking
    if (c.addr[11])
      c.addr[10] = 1'b0;
    send(c, bad);
  endtask

  // odt held at a valid level at all times
  task automatic set_odt(input logic v);
    @(posedge clk_sys);
    #1;
    odt_pin = v;
  endtask
endmodule // dmcf_ctrl_model

/* sim/dram_mode_control_five_bench.sv */
// self-checking bench for the fifth mode-control register
`timescale 1ns/1ps
module dram_mode_control_five_bench
  import dmcf_pkg::*;
;
  logic          clk_sys = 1'b0;
  logic          resetn = 1'b0;
  logic          cs_n_pin, cke_pin, odt_pin;
  dmcf_ca_t      ca_pin, cmd_word_q;
  logic          read_xfer = 0, write_xfer = 0, mpr_read = 0;
  logic          power_down = 0, mps_enter = 0, mps_exit = 0;
  logic          crc_err_evt = 0;
  dmcf_mode_t    mode_reg_q;
  logic          cmd_valid_q, mrs_other_valid_q;
  logic [2:0]    mrs_other_sel_q, park_div_q;
  logic [21:0]   mrs_other_img_q;
  logic          rd_inv_apply_q, wr_inv_apply_q, wr_mask_apply_q;
  dmcf_pin_use_t pin_use_q;
  logic          nom_term_q, mps_active_q;
  int            err_count = 0;
  int            samples_checked = 0;
  logic [31:0]   seed = 32'hff557001;

  always #10 clk_sys = ~clk_sys;

  dmcf_ctrl_model u_ctrl (.clk_sys, .cs_n_pin, .cke_pin, .odt_pin, .ca_pin);

  dmcf_top #(.DQ_WIDTH(8)) u_dut (
    .clk_sys, .resetn, .cs_n_pin, .cke_pin, .odt_pin, .ca_pin,
    .read_xfer, .write_xfer, .mpr_read, .power_down, .mps_enter,
    .mps_exit, .crc_err_evt, .mode_reg_q, .cmd_valid_q, .cmd_word_q,
    .mrs_other_valid_q, .mrs_other_sel_q, .mrs_other_img_q,
    .rd_inv_apply_q, .wr_inv_apply_q, .wr_mask_apply_q, .pin_use_q,
    .nom_term_q, .park_div_q, .mps_active_q);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [2:0] park_exp(input logic [2:0] c);
    logic [2:0] t [8] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1, 3'h5, 3'h3, 3'h7};
    return t[c];
  endfunction

  // refresh command with random bank and address
  function automatic dmcf_ca_t ref_word(input logic [31:0] r);
    dmcf_ca_t w;
    w       = '0;
    w.act_n = 1'b1;
    w.we_n  = 1'b1;
    w.bg    = r[1:0];
    w.ba    = r[3:2];
    w.addr  = r[17:4];
    w.par   = ^w[23:1];
    return w;
  endfunction

  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // edge of the first executed command, counted from the drive edge
  task automatic watch(input logic need, output int n);
    n = 0;
    for (int e = 2; e < 16 && n == 0; e++)
    begin
      @(posedge clk_sys);
      #5;
      if ((cmd_valid_q | mrs_other_valid_q) === 1'b1)
        n = e;
    end
    if (need && n == 0)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic load(input logic [21:0] img, input int lat);
    u_ctrl.mode_set(3'h5, img, 1'b0);
    repeat (3 + lat) @(posedge clk_sys);
    #5;
    if (img[11])
      img[10] = 1'b0;
    chk("mode", {9'h0, img[12:0]}, mode_reg_q);
  endtask

  task automatic strobe(ref logic s);
    @(posedge clk_sys);
    #1;
    s = 1'b1;
    @(posedge clk_sys);
    #1;
    s = 1'b0;
  endtask

  initial
  begin
    logic [21:0] img;
    logic [31:0] r;
    logic [2:0]  s;
    dmcf_ca_t    w;
    int          n;
    int          lat;
    repeat (12) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    @(posedge clk_sys);
    #5;
    chk("reset", 24'h0, mode_reg_q);
    chk("outs", 24'h0, {pin_use_q, park_div_q, mps_active_q});
    for (int i = 0; i < 12; i++)
    begin
      img = rnd() & 22'h001ff8;
      load(img, 0);
      r = rnd();
      u_ctrl.set_odt(r[0]);
      power_down = r[1];
      repeat (4) @(posedge clk_sys);
      #5;
      chk("nom_term", r[0] & !(r[1] & img[5]), nom_term_q);
      chk("park", park_exp(img[8:6]), park_div_q);
    end
    for (int k = 0; k < 2; k++)
    begin
      load(k[0] ? 22'h001800 : 22'h001400, 0);
      for (int i = 0; i < 16; i++)
      begin
        @(posedge clk_sys);
        #1;
        r = rnd();
        {read_xfer, write_xfer, mpr_read} = r[2:0];
        @(posedge clk_sys);
        #5;
        chk("rd_inv", read_xfer & !mpr_read, rd_inv_apply_q);
        chk("wr", {write_xfer & k[0], write_xfer & !k[0]},
            {wr_inv_apply_q, wr_mask_apply_q});
        chk("pin_use", k[0] ? DMCF_PU_INVERT : DMCF_PU_MASK,
            pin_use_q);
      end
    end
    for (int i = 0; i < 8; i++)
    begin
      s = i[2:0];
      img = rnd() & 22'h001bff;
      if (s != 3'h5)
      begin
        u_ctrl.mode_set(s, img, 1'b0);
        watch(s != 3'h7, n);
        chk("other", s == 3'h7 ? 0 : 4, n);
        if (s != 3'h7)
        begin
          chk("sel", s, mrs_other_sel_q);
          chk("img", {1'b0, s, 5'h0, img[12:0]}, mrs_other_img_q);
        end
      end
    end
    chk("mode", 24'h001800, mode_reg_q);
    // gear-down is never on here, so the five-clock code is legal
    lat = 0;
    for (int c = 1; c < 5; c++)
    begin
      load(c[21:0], lat);
      lat = (c == 4) ? 0 : c + 3;
      u_ctrl.set_odt(c[0]);
      w = ref_word(rnd());
      u_ctrl.send(w, 1'b0);
      watch(1'b1, n);
      chk("latency", 4 + lat, n);
      chk("cmd", w, cmd_word_q);
    end
    load(22'h000001, 0);
    u_ctrl.send(ref_word(rnd()), 1'b1);
    watch(1'b0, n);
    chk("dropped", 0, n);
    chk("par_err", 1, mode_reg_q.par_err);
    u_ctrl.send(ref_word(rnd()), 1'b1);
    watch(1'b1, n);
    chk("unchecked", 8, n);
    chk("par_err", 1, mode_reg_q.par_err);
    load(22'h000211, 4);
    u_ctrl.send(ref_word(rnd()), 1'b1);
    watch(1'b0, n);
    chk("persist", 0, n);
    load(22'h000000, 4);
    chk("par_clr", 0, mode_reg_q.par_err);
    strobe(crc_err_evt);
    repeat (6) @(posedge clk_sys);
    #5;
    chk("crc_err", 1, mode_reg_q.crc_err);
    load(22'h000000, 0);
    strobe(mps_enter);
    #4;
    chk("mps", 1, mps_active_q);
    u_ctrl.mode_set(3'h5, 22'h001000, 1'b0);
    watch(1'b0, n);
    chk("mode", 0, mode_reg_q);
    u_ctrl.send(ref_word(rnd()), 1'b0);
    watch(1'b0, n);
    chk("ignored", 0, n);
    strobe(mps_exit);
    #4;
    chk("mps", 0, mps_active_q);
    u_ctrl.send(ref_word(rnd()), 1'b0);
    watch(1'b1, n);
    chk("resumed", 4, n);
    print_verdict();
  end
endmodule // dram_mode_control_five_bench
